// *** rtl/evp_unit.v ***
// evp_unit.v: exception request prioritiser and vector generator
// assumes a cpu that strobes vector requests and an axi4-lite master for registers
// every exception request and flag input is a level from another domain
// Behaviour
// - vector base is register byte then zero
// - up to 58 i-masked requests, offsets 80-f2
// - x-masked request gets base plus f4
// - software or debug entry gets base plus f6
// - opcode exception gets base plus f8
// - three fixed reset vectors ranked in order
// - vector base register resets to all ones
// - reset reinitialises base before reset vector
// - debug active forces upper byte all ones
// - highest vector address wins among pending
// - i-masked needs enable, clear i, no higher
// - x request and non-maskables may nest
// - priority evaluated when cpu asks
// - nothing pending returns spurious vector base+80
// - wake-up registered on the clock; gated-clock wake left to outside logic
// - vector base readable anytime, writable while no reset request is pending
// - pin request highest, others by low byte
// - i flag set blocks i-masked wake-up
// - x request wakes even with x set
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "evp_defs.vh"

module evp_unit #(
	parameter N_IREQ = 58
) (
	// clock and reset
	input wire clk_sys_i,
	input wire reset_i,
	// exception requests (asynchronous sources)
	input wire [N_IREQ-1:0] i_masked_request_i,
	input wire x_masked_pin_request_i,
	input wire software_exception_request_i,
	input wire debug_entry_request_i,
	input wire opcode_exception_request_i,
	input wire power_reset_request_i,
	input wire clkmon_reset_request_i,
	input wire watchdog_timeout_i,
	// cpu condition flags and debug state
	input wire cpu_i_flag_i,
	input wire cpu_x_flag_i,
	input wire debug_active_i,
	// cpu vector interface
	input wire vector_request_i,
	output reg [15:0] vector_address_o,
	output reg vector_valid_o,
	// wake-up to the cpu
	output reg wakeup_o,
	// axi4-lite write address
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	localparam NS = N_IREQ + 10;

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	wire [NS-1:0] raw_in;
	reg [NS-1:0] sync_a;
	reg [NS-1:0] sync_b;
	assign raw_in = {debug_active_i, cpu_x_flag_i, cpu_i_flag_i, watchdog_timeout_i,
		clkmon_reset_request_i, power_reset_request_i, opcode_exception_request_i,
		debug_entry_request_i, software_exception_request_i, x_masked_pin_request_i,
		i_masked_request_i};

	// flags pass the same two stages so they line up with the requests
	// two-stage capture of every outside level
	always @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			sync_a <= {NS{1'b0}};
			sync_b <= {NS{1'b0}};
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
		end
	end

	wire [N_IREQ-1:0] s_ireq = sync_b[N_IREQ-1:0];
	wire s_xreq = sync_b[N_IREQ];
	wire s_swi = sync_b[N_IREQ+1];
	wire s_dbgreq = sync_b[N_IREQ+2];
	wire s_opc = sync_b[N_IREQ+3];
	wire s_por = sync_b[N_IREQ+4];
	wire s_clkmon = sync_b[N_IREQ+5];
	wire s_wdog = sync_b[N_IREQ+6];
	wire s_iflag = sync_b[N_IREQ+7];
	wire s_xflag = sync_b[N_IREQ+8];
	wire s_debug = sync_b[N_IREQ+9];

	// vector request from the cpu runs on this clock: no synchroniser
	reg vreq_d;

	// ------------------------------------------------------------
	// vector base register
	// ------------------------------------------------------------
	reg [7:0] vector_base_reg;
	wire any_reset = s_por | s_clkmon | s_wdog;
	// debug forces the top page so non-maskable vectors reach the debug handler
	wire [7:0] vector_base_upper_byte = s_debug ? `EVP_DEBUG_UPPER : vector_base_reg;

	// ------------------------------------------------------------
	// priority selection
	// ------------------------------------------------------------
	// low byte of the vector for i-masked request index k (k=0 is the pin request)
	function [7:0] ireq_ofs;
		input [6:0] idx;
		begin
			ireq_ofs = `EVP_OFS_IPIN - {idx, 1'b0};
		end
	endfunction

	// i-masked requests, already qualified by their peripheral enable
	// the x request only counts while the x flag is clear
	wire high_pending = s_swi | s_dbgreq | s_opc | (s_xreq & ~s_xflag);
	wire i_allowed = ~s_iflag & ~high_pending;

	reg [7:0] i_ofs;
	reg i_hit;
	integer k;

	// loop depth grows with the number of i-masked inputs
	// scan from lowest rank upward so the highest address overwrites
	always @* begin
		i_ofs = `EVP_OFS_SPURIOUS;
		i_hit = 1'b0;
		for (k = N_IREQ - 1; k >= 0; k = k - 1) begin
			if (s_ireq[k]) begin
				i_ofs = ireq_ofs(k[6:0]);
				i_hit = 1'b1;
			end
		end
	end

	reg [15:0] next_vector;

	// fixed ranking: resets, opcode, software, x, i-masked, spurious
	always @* begin
		if (s_por) begin
			next_vector = `EVP_VEC_POWER;
		end else if (s_clkmon) begin
			next_vector = `EVP_VEC_CLKMON;
		end else if (s_wdog) begin
			next_vector = `EVP_VEC_WATCHDOG;
		end else if (s_opc) begin
			next_vector = {vector_base_upper_byte, `EVP_OFS_OPCODE};
		end else if (s_swi | s_dbgreq) begin
			next_vector = {vector_base_upper_byte, `EVP_OFS_SOFTWARE};
		end else if (s_xreq & ~s_xflag) begin
			next_vector = {vector_base_upper_byte, `EVP_OFS_XPIN};
		end else if (i_hit & i_allowed) begin
			next_vector = {vector_base_upper_byte, i_ofs};
		end else begin
			next_vector = {vector_base_upper_byte, `EVP_OFS_SPURIOUS};
		end
	end

	// a request gone before the strobe leaves the spurious vector
	// vector latched on the request strobe and held while it stays high
	always @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			vreq_d <= 1'b0;
			vector_address_o <= `EVP_VEC_POWER;
			vector_valid_o <= 1'b0;
		end else begin
			vreq_d <= vector_request_i;
			if (vector_request_i & ~vreq_d) begin
				vector_address_o <= next_vector;
			end
			vector_valid_o <= vector_request_i;
		end
	end

	// ------------------------------------------------------------
	// wake-up
	// ------------------------------------------------------------
	// wake terms come from the synchronised levels, so this copy needs the
	// clock; with the clock gated, outside logic must combine the same
	// request levels itself: an x request wakes even with the x flag set
	// and the i flag set keeps every i-masked request from waking
	wire wake_now = s_swi | s_opc | s_xreq | (|s_ireq & ~s_iflag);

	always @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			wakeup_o <= 1'b0;
		end else begin
			wakeup_o <= wake_now;
		end
	end

	// ------------------------------------------------------------
	// register address decode
	// ------------------------------------------------------------
	// true when a bus address selects the vector base register
	function addr_is_vbase;
		input [3:0] a;
		begin
			addr_is_vbase = (a == `EVP_ADDR_VBASE);
		end
	endfunction

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	reg aw_held;
	reg w_held;
	reg [3:0] aw_addr;
	reg [7:0] w_byte;
	reg w_lane0;
	wire wr_go = aw_held & w_held & ~s_axi_bvalid;
	wire base_wr = wr_go & addr_is_vbase(aw_addr) & w_lane0;

	// responses never overlap, so a second write waits for bready
	// write channels taken independently, response once both are in
	always @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `EVP_RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_is_vbase(aw_addr) ? `EVP_RESP_OKAY :
					`EVP_RESP_SLVERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// vector base write
	// ------------------------------------------------------------
	// a reset request reloads all ones ahead of any software write
	always @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			vector_base_reg <= `EVP_VBASE_RESET;
		end else if (any_reset) begin
			vector_base_reg <= `EVP_VBASE_RESET;
		end else if (base_wr) begin
			vector_base_reg <= w_byte;
		end
	end

	// ------------------------------------------------------------
	// register read data
	// ------------------------------------------------------------
	reg [31:0] flags_word;
	reg [31:0] next_rdata;
	reg [1:0] next_rresp;

	// flags word built from its field positions
	always @* begin
		flags_word = 32'h00000000;
		flags_word[`EVP_FLAG_I] = s_iflag;
		flags_word[`EVP_FLAG_X] = s_xflag;
		flags_word[`EVP_FLAG_DEBUG] = s_debug;
		flags_word[`EVP_FLAG_WAKE] = wakeup_o;
	end

	// read data chosen by address; unmapped reads give zero and an error
	always @* begin
		next_rdata = 32'h00000000;
		next_rresp = `EVP_RESP_OKAY;
		case (s_axi_araddr)
			`EVP_ADDR_VBASE: begin
				next_rdata = {24'h000000, vector_base_reg};
			end
			`EVP_ADDR_STATUS: begin
				next_rdata = {16'h0000, next_vector};
			end
			`EVP_ADDR_FLAGS: begin
				next_rdata = flags_word;
			end
			default: begin
				next_rresp = `EVP_RESP_SLVERR;
			end
		endcase
	end

	// read: one cycle to accept, data next cycle
	always @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `EVP_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rresp;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// *** rtl/evp_defs.vh ***
// evp_defs.vh: constants for the exception vector priority unit
// assumes inclusion by the unit's single design file
`ifndef EVP_DEFS_VH
`define EVP_DEFS_VH

// register map (byte addresses on the register bus)
`define EVP_ADDR_VBASE 4'h0
`define EVP_ADDR_STATUS 4'h4
`define EVP_ADDR_FLAGS 4'h8

// vector base reset value and forced upper byte
`define EVP_VBASE_RESET 8'hff
`define EVP_DEBUG_UPPER 8'hff
`define EVP_LOW_ZERO 8'h00

// fixed reset vectors
`define EVP_VEC_POWER 16'hfffe
`define EVP_VEC_CLKMON 16'hfffc
`define EVP_VEC_WATCHDOG 16'hfffa

// low-byte offsets from the vector base
`define EVP_OFS_OPCODE 8'hf8
`define EVP_OFS_SOFTWARE 8'hf6
`define EVP_OFS_XPIN 8'hf4
`define EVP_OFS_IPIN 8'hf2
`define EVP_OFS_SPURIOUS 8'h80

// flags register fields
`define EVP_FLAG_I 0
`define EVP_FLAG_X 1
`define EVP_FLAG_DEBUG 2
`define EVP_FLAG_WAKE 3

// bus responses
`define EVP_RESP_OKAY 2'h0
`define EVP_RESP_SLVERR 2'h2

`endif

// *** tb/evp_chk_assertions.sv ***
// evp_chk_assertions.sv: port checks for the exception vector unit
// assumes the evp_unit ports and one clock domain
`timescale 1ns/100ps
`default_nettype none
module evp_chk #(
	parameter N_IREQ = 58
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// requests and flags
	input wire logic [N_IREQ-1:0] i_masked_request_i,
	input wire logic x_masked_pin_request_i,
	input wire logic software_exception_request_i,
	input wire logic opcode_exception_request_i,
	input wire logic power_reset_request_i,
	input wire logic clkmon_reset_request_i,
	input wire logic watchdog_timeout_i,
	input wire logic cpu_i_flag_i,
	input wire logic debug_active_i,
	// cpu side
	input wire logic vector_request_i,
	input wire logic [15:0] vector_address_o,
	input wire logic vector_valid_o,
	input wire logic wakeup_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	// no reset request pending
	wire no_rst = !power_reset_request_i && !clkmon_reset_request_i && !watchdog_timeout_i;
	chk_valid_rise: assert property (vector_request_i |=> vector_valid_o)
		else $error("vector valid late");
	chk_valid_fall: assert property (!vector_request_i |=> !vector_valid_o)
		else $error("vector valid without request");
	chk_vec_hold: assert property (vector_valid_o && vector_request_i |=> $stable(vector_address_o))
		else $error("vector moved while requested");
	chk_power_vec: assert property (
		power_reset_request_i [*3] ##0 $rose(vector_request_i)
		|=> vector_address_o == 16'hfffe) else $error("power reset vector wrong");
	chk_debug_page: assert property (
		debug_active_i [*3] ##0 $rose(vector_request_i)
		|=> vector_address_o[15:8] == 8'hff) else $error("debug page wrong");
	chk_opcode_vec: assert property (
		(no_rst && opcode_exception_request_i) [*3]
		##0 $rose(vector_request_i) |=> vector_address_o[7:0] == 8'hf8)
		else $error("opcode vector wrong");
	chk_x_wake: assert property (x_masked_pin_request_i [*4] |-> wakeup_o)
		else $error("x request did not wake");
	chk_i_wake: assert property ((i_masked_request_i[0] && !cpu_i_flag_i) [*4] |-> wakeup_o)
		else $error("i request did not wake");
	chk_i_block: assert property (
		(cpu_i_flag_i && !x_masked_pin_request_i &&
		!software_exception_request_i && !opcode_exception_request_i) [*4] |-> !wakeup_o)
		else $error("masked wake seen");
endmodule
bind evp_unit evp_chk #(.N_IREQ(N_IREQ)) chk (
	.clk_sys_i(clk_sys_i),
	.reset_i(reset_i),
	.i_masked_request_i(i_masked_request_i),
	.x_masked_pin_request_i(x_masked_pin_request_i),
	.software_exception_request_i(software_exception_request_i),
	.opcode_exception_request_i(opcode_exception_request_i),
	.power_reset_request_i(power_reset_request_i),
	.clkmon_reset_request_i(clkmon_reset_request_i),
	.watchdog_timeout_i(watchdog_timeout_i),
	.cpu_i_flag_i(cpu_i_flag_i),
	.debug_active_i(debug_active_i),
	.vector_request_i(vector_request_i),
	.vector_address_o(vector_address_o),
	.vector_valid_o(vector_valid_o),
	.wakeup_o(wakeup_o)
);
`default_nettype wire

// *** tb/evp_cpu_model.sv ***
// evp_cpu_model.sv: cpu side that asks the unit for exception vectors
// assumes one clock shared with the unit and a bench that starts each fetch
`timescale 1ns/100ps
`default_nettype none
module evp_cpu_model (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// bench control
	input wire logic start_i,
	input wire logic [1:0] slow_i,
	// vector interface
	input wire logic vec_valid_i,
	input wire logic [15:0] vec_addr_i,
	output logic vreq_o,
	output logic [15:0] got_o,
	output logic done_o
);
	logic [1:0] hold;
	// strobe held until the vector shows, then slow_i more cycles
	always @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			vreq_o <= 1'h0;
			hold <= 2'h0;
			got_o <= 16'h0;
			done_o <= 1'h0;
		end else begin
			done_o <= 1'h0;
			if (start_i) begin
				vreq_o <= 1'h1;
				hold <= slow_i;
			end else if (vreq_o && vec_valid_i) begin
				hold <= hold - 2'h1;
				if (hold == 2'h0) begin
					got_o <= vec_addr_i;
					vreq_o <= 1'h0;
					done_o <= 1'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/evp_unit_tb.sv ***
// evp_unit_tb.sv: self-checking bench for the exception vector unit
// assumes evp_unit, the cpu model and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(a,b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module evp_unit_tb;
	logic clk_sys_i = 0, reset_i = 1, cpu_i_flag_i = 0, cpu_x_flag_i = 0, debug_active_i = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, start = 0, done, vector_request_i, vector_valid_o, wakeup_o;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
	logic [57:0] i_masked_request_i = 0;
	logic [6:0] kind_req = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, slow = 0;
	logic [15:0] vector_address_o, got, expq[$];
	logic [7:0] base;
	logic w;
	integer seed = 32'hfba812bc, n_errors = 0, samples_checked = 0, n, k, t;
	wire x_masked_pin_request_i, debug_entry_request_i, software_exception_request_i;
	wire opcode_exception_request_i, watchdog_timeout_i, clkmon_reset_request_i;
	wire power_reset_request_i;
	// one request kind per bit
	assign {x_masked_pin_request_i, debug_entry_request_i, software_exception_request_i,
		opcode_exception_request_i, watchdog_timeout_i, clkmon_reset_request_i,
		power_reset_request_i} = kind_req;
	// 200 MHz clock
	always #2.5 clk_sys_i = ~clk_sys_i;
	evp_unit #(.N_IREQ(58)) uut (.*);
	evp_cpu_model cpu (.clk_sys_i, .reset_i, .start_i(start), .slow_i(slow),
		.vec_valid_i(vector_valid_o), .vec_addr_i(vector_address_o),
		.vreq_o(vector_request_i), .got_o(got), .done_o(done));
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task limit;
		if (t >= 60) begin
			n_errors++;
			end_of_test;
		end
	endtask
	task wr(input [3:0] a, input [31:0] v);
		@(posedge clk_sys_i);
		{s_axi_awaddr, s_axi_wdata} <= {a, v};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (t = 0; t < 60; t++) begin
			@(posedge clk_sys_i);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 0;
		r = s_axi_bresp;
		limit;
	endtask
	task rd(input [3:0] a);
		@(posedge clk_sys_i);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		for (t = 0; t < 60; t++) begin
			@(posedge clk_sys_i);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 0;
		{d, r} = {s_axi_rdata, s_axi_rresp};
		limit;
	endtask
	// expected vector from the current stimulus
	function logic [15:0] ref_vec;
		logic [7:0] hi;
		hi = debug_active_i ? 8'hff : base;
		ref_vec = {hi, 8'h80};
		for (int j = 57; j >= 0; j--)
			if (i_masked_request_i[j] && !cpu_i_flag_i) ref_vec = {hi, 8'(8'hf2 - 2 * j)};
		case (k)
			0: ref_vec = 16'hfffe;
			1: ref_vec = 16'hfffc;
			2: ref_vec = 16'hfffa;
			3: ref_vec = {hi, 8'hf8};
			4, 5: ref_vec = {hi, 8'hf6};
			6: ref_vec = {hi, 8'hf4};
			default: ;
		endcase
	endfunction
	initial begin
		repeat (20) @(posedge clk_sys_i);
		reset_i <= 0;
		rd(4'h0);
		`CHK(d[7:0], 8'hff)
		wr(4'hc, 32'h1);
		`CHK(r, 2'h2)
		rd(4'hc);
		`CHK(r, 2'h2)
		$display("test registers done");
		for (n = 0; n < 64; n++) begin
			k = n % 8;
			base = 8'($random(seed));
			wr(4'h0, {24'h0, base});
			`CHK(r, 2'h0)
			kind_req <= (k < 7) ? 7'(1 << k) : 7'h0;
			i_masked_request_i <= (n % 16 == 7) ? 58'h0 :
				(58'h1 << (n % 58)) | (58'h1 << ($unsigned($random(seed)) % 58));
			{cpu_i_flag_i, debug_active_i} <= 2'($random(seed));
			cpu_x_flag_i <= (k == 6) ? 1'h0 : 1'($random(seed));
			repeat (4) @(posedge clk_sys_i);
			w = k == 3 || k == 4 || k == 6 || (|i_masked_request_i && !cpu_i_flag_i);
			`CHK(wakeup_o, w)
			rd(4'h8);
			`CHK(d[3:0], {w, debug_active_i, cpu_x_flag_i, cpu_i_flag_i})
			rd(4'h4);
			`CHK(d[15:0], ref_vec())
			expq.push_back(ref_vec());
			@(posedge clk_sys_i);
			{start, slow} <= {1'h1, 2'($random(seed))};
			@(posedge clk_sys_i);
			start <= 0;
			for (t = 0; t < 60 && !done; t++) @(posedge clk_sys_i);
			limit;
			`CHK(got, expq.pop_front())
			kind_req <= 0;
			i_masked_request_i <= 0;
			repeat (3) @(posedge clk_sys_i);
			if (k < 3) base = 8'hff;
			rd(4'h0);
			`CHK(d[7:0], base)
		end
		$display("test vectors done");
		end_of_test;
	end
endmodule
`default_nettype wire
